// file: pkg/fip_regs.svh
// Offsets, field positions, reset values and timing for the fault panel
`ifndef FIP_REGS_SVH
`define FIP_REGS_SVH

// ****************************************
// Slots and codes
// ****************************************
`define FIP_NSLOT 4'd9
`define FIP_TT_SLOT 4'd9
`define FIP_CODE_W 12
`define FIP_DIGITS 3

// ****************************************
// Register map
// ****************************************
`define FIP_OFF_CTRL 8'h00
`define FIP_OFF_STATUS 8'h04
`define FIP_OFF_SLOTS 8'h08
`define FIP_OFF_VERIFY 8'h0c
`define FIP_CTRL_PANEL_EN 0
`define FIP_CTRL_FLASH_EN 1
`define FIP_CTRL_RST 2'h3
`define FIP_HSIZE_WORD 3'h2

// ****************************************
// Panel key vector
// ****************************************
`define FIP_K_SLOT 0
`define FIP_K_SYS 9
`define FIP_K_DIG 17
`define FIP_K_ENT 25
`define FIP_K_FCLR 26
`define FIP_K_DCLR 27
`define FIP_K_ALL 28
`define FIP_K_RST 29
`define FIP_K_N 30

// ****************************************
// Timing
// ****************************************
`define FIP_FLASH_MS 250
`define FIP_CLK_KHZ 100000

`endif

// file: pkg/fip_pkg.sv
// Types shared by the fault panel design
package fip_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SEL, ST_DIGITS, ST_WAIT, ST_INVALID, ST_OP, ST_CLRALL
  } fip_state_type;
  typedef enum logic [1:0] {
    OP_VALIDATE, OP_ACTIVATE, OP_CLEAR, OP_CLEAR_ALL
  } fip_op_type;
  typedef enum logic [1:0] {
    RES_INVALID, RES_ACTIVE, RES_NEW
  } fip_result_type;
endpackage

// file: logic/fip_slot_mem.sv
// Code store for the operator display slots, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module fip_slot_mem #(
  parameter int DEPTH = 9,
  parameter int WIDTH = 12,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] ra_addr,
  output logic [WIDTH-1:0] ra_data,
  input wire logic [AW-1:0] rb_addr,
  output logic [WIDTH-1:0] rb_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("fip_slot_mem: DEPTH does not fit the address width");
  end

  always_ff @(posedge clk) begin
    if (ce && we && int'(waddr) < DEPTH) begin
      mem[waddr] <= wdata;
    end
  end

  // Out-of-range addresses read as zero, shown as a blank readout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ra_data <= '0;
      rb_data <= '0;
    end else if (ce) begin
      ra_data <= (int'(ra_addr) < DEPTH) ? mem[ra_addr] : '0;
      rb_data <= (int'(rb_addr) < DEPTH) ? mem[rb_addr] : '0;
    end
  end
endmodule
`default_nettype wire

// file: logic/fip_core.sv
// Fault insertion panel control logic with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "fip_regs.svh"

module fip_core #(
  parameter int FLASH_CYCLES = `FIP_FLASH_MS * `FIP_CLK_KHZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [8:0] slot_sw,
  input wire logic [7:0] sys_sw,
  input wire logic [7:0] digit_sw,
  input wire logic enter_sw,
  input wire logic fclear_sw,
  input wire logic dclear_sw,
  input wire logic clear_all_sw,
  input wire logic panel_reset_sw,
  input wire logic [3:0] disp_sel,
  output logic [8:0] slot_lamp,
  output logic [7:0] sys_lamp,
  output logic in_use_lamp,
  output logic invalid_lamp,
  output logic clear_all_lamp,
  output logic [8:0] verify_digits,
  output logic [1:0] verify_count,
  output logic [9:0] status_lamp,
  output logic [9:0] active_lamp,
  output logic [9:0] pending_lamp,
  output logic time_tagged_lamp,
  output logic [11:0] disp_code,
  output logic host_req,
  output var fip_pkg::fip_op_type host_op,
  output logic [3:0] host_slot,
  output logic [11:0] host_code,
  input wire logic host_ack,
  input wire logic [1:0] host_result,
  input wire logic tt_impending,
  input wire logic [11:0] tt_code_in,
  input wire logic tt_activate
);
  localparam int FW = $clog2(FLASH_CYCLES + 1);

  if (FLASH_CYCLES < 1) begin : g_bad_flash
    $error("fip_core: FLASH_CYCLES must be at least one");
  end

  fip_pkg::fip_state_type state;
  logic [`FIP_K_N-1:0] key_raw, key_s1, key_s2, key_s3, ev;
  logic ev_rst, ev_all, ev_dclr, ev_fclr, ev_ent, ev_dig, ev_sys, ev_slot;
  logic ev_any, ack, occupied, is_pend;
  logic [3:0] slot_idx, sys_idx, dig_idx, sel_slot, sel_d;
  logic [2:0] sys_code;
  logic panel_clr, sel_go, sys_go, dig_go, inv_go, act_go, fclr_go;
  logic all_go, do_dclear, last_dig, mem_we;
  logic [1:0] ctrl, ctrl_byp;
  logic ap_valid, ap_write, wr_ctrl;
  logic [7:0] ap_addr;
  logic [31:0] rd_word;
  logic [11:0] mem_a, mem_b, tt_code;
  logic tt_on, fl_phase;
  logic [FW-1:0] fl_cnt;

  function automatic logic [3:0] fip_first(input logic [8:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ****************************************
  // Panel key capture
  // ****************************************
  assign key_raw = {panel_reset_sw, clear_all_sw, dclear_sw, fclear_sw,
                    enter_sw, digit_sw, sys_sw, slot_sw};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_s1 <= '0;
      key_s2 <= '0;
      key_s3 <= '0;
    end else if (ce) begin
      key_s1 <= key_raw;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
    end
  end

  // Software can lock the whole panel out
  assign ev = key_s2 & ~key_s3 & {`FIP_K_N{ctrl[`FIP_CTRL_PANEL_EN]}};
  assign ev_rst = ev[`FIP_K_RST];
  assign ev_all = ev[`FIP_K_ALL];
  assign ev_dclr = ev[`FIP_K_DCLR];
  assign ev_fclr = ev[`FIP_K_FCLR];
  assign ev_ent = ev[`FIP_K_ENT];
  assign ev_dig = |ev[`FIP_K_DIG +: 8];
  assign ev_sys = |ev[`FIP_K_SYS +: 8];
  assign ev_slot = |ev[`FIP_K_SLOT +: 9];
  assign ev_any = |ev;
  assign slot_idx = fip_first(ev[`FIP_K_SLOT +: 9]);
  assign sys_idx = fip_first({1'b0, ev[`FIP_K_SYS +: 8]});
  assign dig_idx = fip_first({1'b0, ev[`FIP_K_DIG +: 8]});
  assign ack = host_req && host_ack;
  assign occupied = status_lamp[sel_slot];
  assign is_pend = pending_lamp[sel_slot];
  assign last_dig = verify_count == 2'(`FIP_DIGITS - 1);

  // ****************************************
  // Register slave
  // ****************************************
  assign wr_ctrl = ap_valid && ap_write && ap_addr == `FIP_OFF_CTRL;
  assign ctrl_byp = wr_ctrl ? hwdata[1:0] : ctrl;

  always_comb begin
    rd_word = 32'h0;
    case (haddr[7:0])
      `FIP_OFF_CTRL: rd_word = {30'h0, ctrl_byp};
      `FIP_OFF_STATUS: rd_word = {20'h0, tt_on, clear_all_lamp, host_req,
                                  invalid_lamp, sel_slot, 1'b0, state};
      `FIP_OFF_SLOTS: rd_word = {6'h0, active_lamp, 6'h0, pending_lamp};
      `FIP_OFF_VERIFY: rd_word = {18'h0, sys_code, verify_count,
                                  verify_digits};
      default: rd_word = 32'h0;
    endcase
  end

  // Zero wait states, so every transfer ends in its first data cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl <= `FIP_CTRL_RST;
    end else if (ce) begin
      ap_valid <= hsel && htrans[1] && hready;
      ap_write <= hwrite && hsize == `FIP_HSIZE_WORD;
      ap_addr <= haddr[7:0];
      hrdata <= (hsel && htrans[1] && hready && !hwrite) ? rd_word : 32'h0;
      if (wr_ctrl) begin
        ctrl <= hwdata[1:0];
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  always_comb begin
    panel_clr = 1'b0;
    sel_go = 1'b0;
    sys_go = 1'b0;
    dig_go = 1'b0;
    inv_go = 1'b0;
    act_go = 1'b0;
    fclr_go = 1'b0;
    all_go = 1'b0;
    do_dclear = 1'b0;
    unique case (state)
      fip_pkg::ST_IDLE, fip_pkg::ST_SEL, fip_pkg::ST_DIGITS: begin
        if (ev_rst) begin
          panel_clr = 1'b1;
        end else if (ev_all) begin
          all_go = 1'b1;
        end else if (state == fip_pkg::ST_SEL && ev_dclr && occupied) begin
          do_dclear = 1'b1;
        end else if (ev_slot && state != fip_pkg::ST_DIGITS) begin
          sel_go = 1'b1;
        end else if (ev_sys && state == fip_pkg::ST_SEL && !occupied) begin
          sys_go = 1'b1;
        end else if (ev_dig && state == fip_pkg::ST_DIGITS) begin
          dig_go = 1'b1;
        end else if (ev_ent && state == fip_pkg::ST_SEL && is_pend) begin
          act_go = 1'b1;
        end else if (ev_fclr && state == fip_pkg::ST_SEL && occupied) begin
          fclr_go = 1'b1;
        end else if (ev_any) begin
          inv_go = 1'b1;
        end
      end
      fip_pkg::ST_INVALID: panel_clr = ev_rst;
      fip_pkg::ST_WAIT: begin
        inv_go = ack && host_result == fip_pkg::RES_INVALID;
        panel_clr = ack && host_result == fip_pkg::RES_NEW;
      end
      fip_pkg::ST_OP, fip_pkg::ST_CLRALL: panel_clr = ack;
    endcase
  end

  // ****************************************
  // Sequence and host exchange
  // ****************************************
  // No key is looked at in WAIT, OP or CLRALL
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= fip_pkg::ST_IDLE;
      sel_slot <= 4'h0;
    end else if (ce) begin
      if (panel_clr || do_dclear) begin
        state <= fip_pkg::ST_IDLE;
      end else if (inv_go) begin
        state <= fip_pkg::ST_INVALID;
      end else if (all_go) begin
        state <= fip_pkg::ST_CLRALL;
      end else if (sel_go) begin
        state <= fip_pkg::ST_SEL;
        sel_slot <= slot_idx;
      end else if (sys_go) begin
        state <= fip_pkg::ST_DIGITS;
      end else if (dig_go && last_dig) begin
        state <= fip_pkg::ST_WAIT;
      end else if (act_go || fclr_go) begin
        state <= fip_pkg::ST_OP;
      end else if (state == fip_pkg::ST_WAIT && ack) begin
        state <= fip_pkg::ST_SEL;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_req <= 1'b0;
      host_op <= fip_pkg::OP_VALIDATE;
      host_slot <= 4'h0;
      host_code <= 12'h000;
    end else if (ce) begin
      if (ack) begin
        host_req <= 1'b0;
      end else if (dig_go && last_dig) begin
        host_req <= 1'b1;
        host_op <= fip_pkg::OP_VALIDATE;
        host_slot <= sel_slot;
        host_code <= {sys_code, verify_digits[5:0], dig_idx[2:0]};
      end else if (act_go || fclr_go) begin
        host_req <= 1'b1;
        host_op <= act_go ? fip_pkg::OP_ACTIVATE : fip_pkg::OP_CLEAR;
        host_slot <= sel_slot;
        host_code <= mem_b;
      end else if (all_go) begin
        host_req <= 1'b1;
        host_op <= fip_pkg::OP_CLEAR_ALL;
      end
    end
  end

  // ****************************************
  // Control panel indications
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_lamp <= 9'h000;
      sys_lamp <= 8'h00;
      in_use_lamp <= 1'b0;
      invalid_lamp <= 1'b0;
      clear_all_lamp <= 1'b0;
      verify_digits <= 9'h000;
      verify_count <= 2'h0;
      sys_code <= 3'h0;
    end else if (ce) begin
      if (panel_clr || do_dclear || all_go) begin
        slot_lamp <= 9'h000;
        sys_lamp <= 8'h00;
        in_use_lamp <= 1'b0;
        invalid_lamp <= 1'b0;
        verify_digits <= 9'h000;
        verify_count <= 2'h0;
      end else if (inv_go) begin
        invalid_lamp <= 1'b1;
      end else if (sel_go) begin
        slot_lamp <= 9'h001 << slot_idx;
        in_use_lamp <= 1'b1;
        sys_lamp <= 8'h00;
        verify_digits <= 9'h000;
        verify_count <= 2'h0;
      end else if (sys_go) begin
        sys_lamp <= ev[`FIP_K_SYS +: 8];
        sys_code <= sys_idx[2:0];
      end else if (dig_go) begin
        verify_digits <= {verify_digits[5:0], dig_idx[2:0]};
        verify_count <= verify_count + 2'd1;
      end
      if (all_go) begin
        clear_all_lamp <= 1'b1;
      end else if (state == fip_pkg::ST_CLRALL && ack) begin
        clear_all_lamp <= 1'b0;
      end
    end
  end

  // ****************************************
  // Display panel slots
  // ****************************************
  // Lamps carry entered, active and pending per slot, set from the host answer and operation, the display clear and the time-tagged inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_lamp <= 10'h000;
      active_lamp <= 10'h000;
      pending_lamp <= 10'h000;
    end else if (ce) begin
      if (state == fip_pkg::ST_CLRALL && ack) begin
        status_lamp <= 10'h000;
        active_lamp <= 10'h000;
        pending_lamp <= 10'h000;
      end else begin
        if (state == fip_pkg::ST_WAIT && ack &&
            host_result != fip_pkg::RES_INVALID) begin
          status_lamp[sel_slot] <= 1'b1;
          active_lamp[sel_slot] <= host_result == fip_pkg::RES_ACTIVE;
          pending_lamp[sel_slot] <= host_result == fip_pkg::RES_NEW;
        end
        if (state == fip_pkg::ST_OP && ack) begin
          if (host_op == fip_pkg::OP_ACTIVATE) begin
            active_lamp[host_slot] <= 1'b1;
            pending_lamp[host_slot] <= 1'b0;
          end else begin
            status_lamp[host_slot] <= 1'b0;
            active_lamp[host_slot] <= 1'b0;
            pending_lamp[host_slot] <= 1'b0;
          end
        end
        if (do_dclear) begin
          status_lamp[sel_slot] <= 1'b0;
          active_lamp[sel_slot] <= 1'b0;
          pending_lamp[sel_slot] <= 1'b0;
        end
        if (tt_impending) begin
          status_lamp[`FIP_TT_SLOT] <= 1'b1;
          pending_lamp[`FIP_TT_SLOT] <= 1'b1;
        end else if (tt_activate) begin
          status_lamp[`FIP_TT_SLOT] <= 1'b0;
          pending_lamp[`FIP_TT_SLOT] <= 1'b0;
        end
      end
    end
  end

  // Reserved slot keeps its code here; operator slots use the memory
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tt_on <= 1'b0;
      tt_code <= 12'h000;
      fl_cnt <= '0;
      fl_phase <= 1'b0;
      time_tagged_lamp <= 1'b0;
    end else if (ce) begin
      if (state == fip_pkg::ST_CLRALL && ack) begin
        tt_on <= 1'b0;
      end else if (tt_impending) begin
        tt_on <= 1'b1;
        tt_code <= tt_code_in;
      end else if (tt_activate) begin
        tt_on <= 1'b0;
      end
      if (!tt_on || fl_cnt == FW'(FLASH_CYCLES - 1)) begin
        fl_cnt <= '0;
        fl_phase <= tt_on && !fl_phase;
      end else begin
        fl_cnt <= fl_cnt + 1'b1;
      end
      time_tagged_lamp <= tt_on &&
                          (fl_phase || !ctrl[`FIP_CTRL_FLASH_EN]);
    end
  end

  assign mem_we = state == fip_pkg::ST_WAIT && ack &&
                  host_result != fip_pkg::RES_INVALID;

  fip_slot_mem #(
    .DEPTH(9),
    .WIDTH(`FIP_CODE_W),
    .AW(4)
  ) u_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .we(mem_we),
    .waddr(sel_slot),
    .wdata(host_code),
    .ra_addr(disp_sel),
    .ra_data(mem_a),
    .rb_addr(sel_slot),
    .rb_data(mem_b)
  );

  // Dark slots read blank whatever the memory still holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_d <= 4'h0;
      disp_code <= 12'h000;
    end else if (ce) begin
      sel_d <= disp_sel;
      if (sel_d > `FIP_TT_SLOT || !status_lamp[sel_d]) begin
        disp_code <= 12'h000;
      end else begin
        disp_code <= (sel_d == `FIP_TT_SLOT) ? tt_code : mem_a;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TT_RESERVED: assert property (in_use_lamp |-> sel_slot < `FIP_NSLOT)
    else $error("operator selected the reserved slot");
  AST_SELECT_LAMPS: assert property (ce && sel_go |=> in_use_lamp &&
    slot_lamp == (9'h001 << $past(slot_idx))) else $error("select lamps");
  AST_THREE_DIGITS: assert property (ce && dig_go && last_dig |=>
    host_req && host_code[11:9] == sys_code && state == fip_pkg::ST_WAIT)
    else $error("third digit did not start the exchange");
  AST_VERIFY_ECHO: assert property (ce && dig_go |=>
    verify_digits[2:0] == $past(dig_idx[2:0]) &&
    verify_count == $past(verify_count) + 2'd1) else $error("verify echo");
  AST_HOST_OUTCOME: assert property (ce && ack &&
    state == fip_pkg::ST_WAIT |=> !host_req && state inside
    {fip_pkg::ST_INVALID, fip_pkg::ST_SEL, fip_pkg::ST_IDLE})
    else $error("exchange did not end in one outcome");
  AST_INVALID_HOLD: assert property (ce && state == fip_pkg::ST_INVALID &&
    !ev_rst |=> state == fip_pkg::ST_INVALID && invalid_lamp)
    else $error("invalid lock released without panel reset");
  AST_ALREADY_ACTIVE: assert property (ce && ack &&
    state == fip_pkg::ST_WAIT && host_result == fip_pkg::RES_ACTIVE |=>
    active_lamp[sel_slot] && status_lamp[sel_slot]) else $error("entered");
  AST_PENDING_NEW: assert property (ce && ack &&
    state == fip_pkg::ST_WAIT && host_result == fip_pkg::RES_NEW |=>
    pending_lamp[$past(sel_slot)] && !in_use_lamp && slot_lamp == 9'h000)
    else $error("pending outcome");
  AST_ACTIVATE: assert property (ce && ack && state == fip_pkg::ST_OP &&
    host_op == fip_pkg::OP_ACTIVATE |=> active_lamp[$past(host_slot)] &&
    !pending_lamp[$past(host_slot)] && !in_use_lamp) else $error("activate");
  AST_CLEAR_ALL: assert property (ce && ack &&
    state == fip_pkg::ST_CLRALL |=> status_lamp == 10'h000 &&
    !clear_all_lamp ##1 disp_code == 12'h000) else $error("clear all");
  AST_DISPLAY_CLEAR: assert property (ce && do_dclear |=>
    !status_lamp[$past(sel_slot)] && !host_req) else $error("display clear");
  AST_TT_DONE: assert property (ce && tt_activate && !tt_impending &&
    !(state == fip_pkg::ST_CLRALL && ack) |=> !status_lamp[`FIP_TT_SLOT]
    ##1 !time_tagged_lamp) else $error("time-tagged slot not cleared");
  AST_ONE_EVENT: assert property ((ce && ev_any) ##1 ce |->
    (ev & $past(ev)) == '0) else $error("press gave two events");
  AST_IGNORE_BUSY: assert property (ce && state == fip_pkg::ST_WAIT &&
    !ack |=> $stable(verify_digits) && state == fip_pkg::ST_WAIT)
    else $error("key taken during host exchange");

  COV_NEW: cover property (state == fip_pkg::ST_WAIT && ack &&
    host_result == fip_pkg::RES_NEW);
  COV_ACT: cover property (state == fip_pkg::ST_OP && ack &&
    host_op == fip_pkg::OP_ACTIVATE);
  COV_ALL: cover property (state == fip_pkg::ST_CLRALL && ack);
  COV_TT: cover property (tt_on && time_tagged_lamp);
endmodule
`default_nettype wire

// file: logic/README_placeholder_none.sv
// Empty unit, holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: bench/fip_host_model.sv
// Behavioural host computer that answers one panel request at a time
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Host answer logic
// ****************************************
module fip_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic host_req,
  input wire logic [1:0] res_cfg,
  input wire logic [3:0] dly,
  output logic host_ack,
  output logic [1:0] host_result
);
  logic [3:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      host_ack <= 1'b0;
      host_result <= 2'h3;
    end else if (host_req && !host_ack && cnt == dly) begin
      cnt <= 4'h0;
      host_ack <= 1'b1;
      host_result <= res_cfg;
    end else begin
      // Result is only meaningful with ack, so it toggles otherwise
      cnt <= (host_req && !host_ack) ? cnt + 4'h1 : 4'h0;
      host_ack <= 1'b0;
      host_result <= ~host_result;
    end
  end
endmodule
`default_nettype wire

// file: bench/fip_core_tb.sv
// Self-checking bench for the fault panel core
`timescale 1ns/1ps
`default_nettype none
`include "fip_regs.svh"
// ****************************************
// Bench top
// ****************************************
module fip_core_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ce = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0, res_cfg = 2'h2, verify_count, host_result;
  logic [2:0] hsize = 3'h0;
  logic [29:0] keys = 30'h0;
  logic [3:0] disp_sel = 4'h0, dly = 4'h2, host_slot;
  logic tt_impending = 1'b0, tt_activate = 1'b0, hreadyout, hresp, host_ack;
  logic in_use_lamp, invalid_lamp, clear_all_lamp, time_tagged_lamp, host_req;
  logic [8:0] slot_lamp, verify_digits;
  logic [7:0] sys_lamp;
  logic [9:0] status_lamp, active_lamp, pending_lamp;
  logic [11:0] disp_code, host_code, tt_code_in = 12'h0;
  fip_pkg::fip_op_type host_op;
  int n_fail = 0, samples_checked = 0, hi;
  fip_core #(.FLASH_CYCLES(4)) dut (.hclk, .hresetn, .ce, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .slot_sw(keys[8:0]), .sys_sw(keys[`FIP_K_SYS+:8]),
    .digit_sw(keys[`FIP_K_DIG+:8]), .enter_sw(keys[`FIP_K_ENT]),
    .fclear_sw(keys[`FIP_K_FCLR]), .dclear_sw(keys[`FIP_K_DCLR]),
    .clear_all_sw(keys[`FIP_K_ALL]), .panel_reset_sw(keys[`FIP_K_RST]),
    .disp_sel, .slot_lamp, .sys_lamp, .in_use_lamp, .invalid_lamp,
    .clear_all_lamp, .verify_digits, .verify_count, .status_lamp, .active_lamp,
    .pending_lamp, .time_tagged_lamp, .disp_code, .host_req, .host_op,
    .host_slot, .host_code, .host_ack, .host_result, .tt_impending,
    .tt_code_in, .tt_activate);
  fip_host_model host (.hclk, .hresetn, .host_req, .res_cfg, .dly, .host_ack,
    .host_result);
  always #5 hclk = ~hclk;
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= `FIP_HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // Level held past the synchroniser, then a gap before the next key
  task press(input int k);
    keys[k] <= 1'b1;
    repeat (4) @(posedge hclk);
    keys[k] <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task settle;
    int n;
    n = 0;
    while (host_req !== 1'b0 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    chk(host_req, 1'b0);
    repeat (3) @(posedge hclk);
  endtask
  // Lit cycles of the time-tagged lamp over one flash period
  task lamp_on(input int e);
    hi = 0;
    repeat (8) begin
      @(posedge hclk);
      hi += int'(time_tagged_lamp);
    end
    chk(hi, e);
  endtask
  task entry(input int s, input int l, input logic [8:0] c, input int res);
    res_cfg <= res[1:0];
    press(s);
    chk({in_use_lamp, slot_lamp}, {1'b1, 9'h1 << s});
    press(`FIP_K_SYS + l);
    chk(sys_lamp, 8'h1 << l);
    for (int i = 2; i >= 0; i--) begin
      press(`FIP_K_DIG + c[3*i+:3]);
      if (i > 0)
        chk({verify_count, verify_digits[2:0]}, {2'(3 - i), c[3*i+:3]});
    end
    if (host_req === 1'b1)
      chk({host_op, host_slot, host_code}, {2'd0, 4'(s), 3'(l), c});
    settle();
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #300us;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(`FIP_OFF_CTRL, 1'b0, 32'h0);
    chk(r, 32'h3);
    chk({hreadyout, hresp}, 2'h2);
    bus(8'h10, 1'b0, 32'h0);
    chk(r, 32'h0);
    $display("end of test registers");
    entry(0, 2, 9'o123, 2);
    chk({pending_lamp[0], status_lamp[0], in_use_lamp, slot_lamp}, 12'hc00);
    repeat (3) @(posedge hclk);
    chk(disp_code, 12'o2123);
    dly <= 4'h9;
    entry(3, 7, 9'o777, 2);
    chk(pending_lamp[3:0], 4'h9);
    $display("end of test pending");
    press(0);
    press(`FIP_K_ENT);
    chk({host_op, host_slot, host_code}, {2'd1, 4'd0, 12'o2123});
    settle();
    chk({active_lamp[0], pending_lamp[0], slot_lamp}, 11'h400);
    press(3);
    press(`FIP_K_ENT);
    settle();
    chk({active_lamp[3], pending_lamp[3], in_use_lamp}, 3'h4);
    $display("end of test activate");
    entry(5, 1, 9'o042, 1);
    chk({active_lamp[5], status_lamp[5], pending_lamp[5]}, 3'h6);
    press(`FIP_K_FCLR);
    chk({host_op, host_slot, host_code}, {2'd2, 4'd5, 12'o1042});
    settle();
    chk({active_lamp[5], status_lamp[5], slot_lamp}, 11'h0);
    entry(6, 0, 9'o001, 0);
    chk(invalid_lamp, 1'b1);
    press(`FIP_K_DIG);
    chk({invalid_lamp, host_req}, 2'h2);
    press(`FIP_K_RST);
    chk({invalid_lamp, slot_lamp, in_use_lamp}, 11'h0);
    $display("end of test answers");
    disp_sel <= 4'h0;
    press(0);
    press(`FIP_K_DCLR);
    repeat (3) @(posedge hclk);
    chk({status_lamp[0], active_lamp[0], active_lamp[3], disp_code},
        15'h1000);
    tt_code_in <= 12'o3456;
    tt_impending <= 1'b1;
    @(posedge hclk);
    tt_impending <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({status_lamp[9], pending_lamp[9]}, 2'h3);
    disp_sel <= 4'h9;
    lamp_on(4);
    chk(disp_code, 12'o3456);
    bus(`FIP_OFF_CTRL, 1'b1, 32'h1);
    @(posedge hclk);
    lamp_on(8);
    bus(`FIP_OFF_CTRL, 1'b1, 32'h0);
    press(0);
    chk({in_use_lamp, slot_lamp}, 10'h0);
    bus(`FIP_OFF_CTRL, 1'b1, 32'h3);
    ce <= 1'b0;
    press(0);
    ce <= 1'b1;
    chk({in_use_lamp, slot_lamp}, 10'h0);
    bus(`FIP_OFF_CTRL, 1'b0, 32'h0);
    chk(r, 32'h3);
    $display("end of test control");
    tt_activate <= 1'b1;
    @(posedge hclk);
    tt_activate <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({status_lamp[9], pending_lamp[9], time_tagged_lamp}, 3'h0);
    dly <= 4'hf;
    press(`FIP_K_ALL);
    chk({clear_all_lamp, host_op}, 3'h7);
    settle();
    chk({clear_all_lamp, status_lamp, active_lamp}, 21'h0);
    $display("end of test clearing");
    summarize();
  end
endmodule
`default_nettype wire
